// file: ltxc_pkg.sv
// constants and carrier types for the laser transmit control and safety block
// Operation
// RULE1: differential output default, single-ended when set
// RULE2: single-ended select picks negative output
// RULE3: four-bit de-emphasis amount drives output
// RULE4: peaking width select widens de-emphasis
// RULE5: delay mode delays de-emphasis, falling edge
// RULE6: slow edge mode; host sets below 0xc0
// RULE7: amplitude follows pin when control bit set
// RULE8: eight-bit setting sets modulation current
// RULE9: powerdown disables whole transmit path
// RULE10: offset cancel on unless disable set
// RULE11: crosspoint sign direction, seven-bit magnitude
// RULE12: bias off after reset until enabled
// RULE13: open loop uses setting, else loop
// RULE14: photodiode polarity selects sink or source
// RULE15: two-bit photodiode range picks current range
// RULE16: bias sources by default, sinks when set
// RULE17: monitor selects route currents to digital word
// RULE18: bias fault by analog or threshold
// RULE19: photodiode fault by analog or threshold
// RULE20: fault on overcurrent or large bias drop
// RULE21: fault zeroes bias, latches pin, status
// RULE22: toggle disable or enable to recover
package ltxc_pkg;

   // ----------------------------------------------------------------
   // widths and timing
   // ----------------------------------------------------------------
   localparam int MOD_W   = 8;
   localparam int BIAS_W  = 10;
   localparam int MON_W   = 10;
   localparam int THR_W   = 8;
   localparam int CP_W    = 7;
   localparam int DE_W    = 4;
   localparam int RNG_W   = 2;

   localparam int CLK_PERIOD_NS     = 50;
   // fault latch reset time, default plain value
   localparam int LATCH_RESET_NS    = 1000;
   localparam int LATCH_RESET_CYC   = (LATCH_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [MOD_W-1:0]  SLOW_EDGE_LIMIT = 8'hc0;
   localparam logic [BIAS_W-1:0] BIAS_ZERO       = 10'h000;
   localparam logic [MON_W-1:0]  MON_ZERO        = 10'h000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                  output_mode_single_ended;
      logic                  single_ended_output_select;
      logic [DE_W-1:0]       deemphasis_amount;
      logic                  peaking_width_select;
      logic                  deemphasis_delay_mode;
      logic                  slow_edge_mode;
      logic                  amplitude_pin_control;
      logic [MOD_W-1:0]      modulation_setting;
      logic                  transmit_path_powerdown;
      logic                  offset_cancel_disable;
      logic                  crosspoint_sign;
      logic [CP_W-1:0]       crosspoint_adjust;
   } ltxc_out_cfg_s;

   typedef struct packed {
      logic                  positive_out_en;
      logic                  negative_out_en;
      logic                  deemphasis_on;
      logic [DE_W-1:0]       deemphasis_level;
      logic                  deemphasis_wide;
      logic                  deemphasis_delayed;
      logic                  slow_edges;
      logic                  amp_from_pin;
      logic [MOD_W-1:0]      modulation_code;
      logic                  path_powered;
      logic                  offset_cancel_on;
      logic                  crosspoint_toward_one;
      logic [CP_W-1:0]       crosspoint_shift;
   } ltxc_drv_s;

   typedef struct packed {
      logic                  bias_enable;
      logic                  open_loop_select;
      logic [BIAS_W-1:0]     bias_setting;
      logic                  photodiode_polarity;
      logic [RNG_W-1:0]      photodiode_range;
      logic                  bias_sink_select;
      logic                  bias_digital_monitor_select;
      logic                  photodiode_digital_monitor_select;
      logic                  fault_detect_enable;
      logic [THR_W-1:0]      bias_fault_threshold;
      logic                  analog_photodiode_fault_trigger;
      logic [THR_W-1:0]      photodiode_fault_threshold;
   } ltxc_bias_cfg_s;

   typedef struct packed {
      logic                  bias_monitor_pin_high;
      logic                  photodiode_monitor_pin_high;
      logic [MON_W-1:0]      bias_current;
      logic [MON_W-1:0]      photodiode_current;
      logic [MON_W-1:0]      photodiode_set;
   } ltxc_sense_s;

   typedef enum logic [1:0] {
      LTXC_OFF,
      LTXC_RUN,
      LTXC_FAULT,
      LTXC_CLEAR
   } ltxc_state_e;

endpackage

// file: ltxc_fault_detect.sv
// fault condition detector for the laser safety logic
`timescale 1ns/100ps
module ltxc_fault_detect
   import ltxc_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   input  wire logic              armed,
   input  wire ltxc_bias_cfg_s    cfg,
   input  wire ltxc_sense_s       sense,
   input  wire logic [BIAS_W-1:0] bias_cmd,
   output logic                   fault_now
);

   logic [BIAS_W-1:0] bias_prev_r;
   logic              bias_fault;
   logic              pd_fault;
   logic              pd_over;
   logic              bias_drop;
   logic [MON_W+1:0]  pd_x2;
   logic [MON_W+1:0]  pd_set_x3;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bias_prev_r <= BIAS_ZERO;
      end else begin
         bias_prev_r <= bias_cmd;
      end
   end

   assign pd_x2     = {1'b0, sense.photodiode_current, 1'b0};
   assign pd_set_x3 = {2'b00, sense.photodiode_set} + {1'b0, sense.photodiode_set, 1'b0};

   always_comb begin
      bias_fault = sense.bias_monitor_pin_high
         || (cfg.bias_digital_monitor_select
             && (sense.bias_current > {2'b00, cfg.bias_fault_threshold})); // RULE18
      pd_fault = (sense.photodiode_monitor_pin_high && cfg.analog_photodiode_fault_trigger)
         || (cfg.photodiode_digital_monitor_select
             && (sense.photodiode_current > {2'b00, cfg.photodiode_fault_threshold})); // RULE19
      pd_over   = pd_x2 > pd_set_x3; // RULE20
      bias_drop = ({1'b0, bias_cmd, 1'b0} < {2'b00, bias_prev_r}); // RULE20
   end

   assign fault_now = armed && cfg.fault_detect_enable
                      && (bias_fault || pd_fault || pd_over || bias_drop);

   AST_DROP_FLAGS: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE20
      (armed && cfg.fault_detect_enable && (bias_cmd < (bias_prev_r >> 1))) |-> fault_now)
      else $error("bias drop above half not flagged");

endmodule

// file: ltxc_top.sv
// laser transmit control and fault safety top
`timescale 1ns/100ps
module ltxc_top
   import ltxc_pkg::*;
#(
   parameter int LATCH_CYC = LATCH_RESET_CYC
)
(
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   input  wire ltxc_out_cfg_s     out_cfg,
   input  wire ltxc_bias_cfg_s    bias_cfg,
   input  wire ltxc_sense_s       sense,
   input  wire logic [BIAS_W-1:0] loop_bias,
   input  wire logic              transmit_disable_pin,
   output ltxc_drv_s              drv,
   output logic [BIAS_W-1:0]      bias_out,
   output logic                   bias_sink,
   output logic                   bias_on,
   output logic                   photodiode_sink,
   output logic [RNG_W-1:0]       photodiode_range_sel,
   output logic                   closed_loop_on,
   output logic [MON_W-1:0]       digital_monitor,
   output logic                   digital_monitor_valid,
   output logic                   fault_output,
   output logic                   fault_status,
   output logic                   slow_edge_advised
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ltxc_state_e        state_r;
   ltxc_state_e        state_nxt;
   logic [15:0]        clr_cnt_r;
   logic               fault_now;
   logic               enabled;
   logic [BIAS_W-1:0]  bias_cmd;
   logic               clr_done;
   ltxc_drv_s          drv_nxt;

   assign enabled  = bias_cfg.bias_enable && !transmit_disable_pin;
   assign bias_cmd = bias_cfg.open_loop_select ? bias_cfg.bias_setting : loop_bias; // RULE13
   assign clr_done = clr_cnt_r >= 16'(LATCH_CYC);

   ltxc_fault_detect u_detect (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .armed     (state_r != LTXC_OFF),
      .cfg       (bias_cfg),
      .sense     (sense),
      .bias_cmd  (bias_cmd),
      .fault_now (fault_now)
   );

   // ----------------------------------------------------------------
   // safety sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         LTXC_OFF: begin
            if (enabled) begin
               state_nxt = LTXC_RUN; // RULE12
            end
         end
         LTXC_RUN: begin
            if (fault_now) begin
               state_nxt = LTXC_FAULT; // RULE21
            end else if (!enabled) begin
               state_nxt = LTXC_OFF;
            end
         end
         LTXC_FAULT: begin
            if (!enabled) begin
               state_nxt = LTXC_CLEAR; // RULE22
            end
         end
         LTXC_CLEAR: begin
            // early return or standing fault relatches
            if (enabled) begin
               state_nxt = (clr_done && !fault_now) ? LTXC_RUN : LTXC_FAULT; // RULE22
            end
         end
         default: begin
            state_nxt = LTXC_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_r <= LTXC_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         clr_cnt_r <= 16'h0000;
      end else if (state_nxt != LTXC_CLEAR) begin
         clr_cnt_r <= 16'h0000;
      end else if (!clr_done) begin
         clr_cnt_r <= clr_cnt_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // bias and fault outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bias_out     <= BIAS_ZERO;
         bias_on      <= 1'b0;
         fault_output <= 1'b0;
         fault_status <= 1'b0;
      end else begin
         // a fresh fault zeroes bias in the same edge it latches
         bias_on      <= (state_nxt == LTXC_RUN); // RULE12 RULE21
         bias_out     <= (state_nxt == LTXC_RUN) ? bias_cmd : BIAS_ZERO; // RULE13 RULE21
         fault_output <= (state_nxt == LTXC_FAULT); // RULE21 RULE22
         fault_status <= (state_nxt == LTXC_FAULT); // RULE21
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bias_sink            <= 1'b0;
         photodiode_sink      <= 1'b0;
         photodiode_range_sel <= '0;
         closed_loop_on       <= 1'b0;
      end else begin
         bias_sink            <= bias_cfg.bias_sink_select; // RULE16
         photodiode_sink      <= bias_cfg.photodiode_polarity; // RULE14
         photodiode_range_sel <= bias_cfg.photodiode_range; // RULE15
         closed_loop_on       <= !bias_cfg.open_loop_select && (state_nxt == LTXC_RUN); // RULE13
      end
   end

   // ----------------------------------------------------------------
   // digital monitor
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         digital_monitor       <= MON_ZERO;
         digital_monitor_valid <= 1'b0;
      end else if (bias_cfg.bias_digital_monitor_select) begin
         digital_monitor       <= sense.bias_current; // RULE17
         digital_monitor_valid <= 1'b1;
      end else if (bias_cfg.photodiode_digital_monitor_select) begin
         digital_monitor       <= sense.photodiode_current; // RULE17
         digital_monitor_valid <= 1'b1;
      end else begin
         digital_monitor       <= MON_ZERO;
         digital_monitor_valid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // output driver controls
   // ----------------------------------------------------------------
   always_comb begin
      drv_nxt.positive_out_en = !out_cfg.output_mode_single_ended
                                || !out_cfg.single_ended_output_select; // RULE1 RULE2
      drv_nxt.negative_out_en = !out_cfg.output_mode_single_ended
                                || out_cfg.single_ended_output_select; // RULE1 RULE2
      drv_nxt.deemphasis_on         = out_cfg.deemphasis_amount != '0; // RULE3
      drv_nxt.deemphasis_level      = out_cfg.deemphasis_amount; // RULE3
      drv_nxt.deemphasis_wide       = out_cfg.peaking_width_select; // RULE4
      drv_nxt.deemphasis_delayed    = out_cfg.deemphasis_delay_mode; // RULE5
      drv_nxt.slow_edges            = out_cfg.slow_edge_mode; // RULE6
      drv_nxt.amp_from_pin          = out_cfg.amplitude_pin_control; // RULE7
      drv_nxt.modulation_code       = out_cfg.modulation_setting; // RULE8
      drv_nxt.path_powered          = !out_cfg.transmit_path_powerdown; // RULE9
      drv_nxt.offset_cancel_on      = !out_cfg.offset_cancel_disable; // RULE10
      drv_nxt.crosspoint_toward_one = out_cfg.crosspoint_sign; // RULE11
      drv_nxt.crosspoint_shift      = out_cfg.crosspoint_adjust; // RULE11
      if (out_cfg.transmit_path_powerdown) begin
         // powered-down path drives nothing
         drv_nxt.positive_out_en = 1'b0; // RULE9
         drv_nxt.negative_out_en = 1'b0; // RULE9
         drv_nxt.deemphasis_on   = 1'b0; // RULE9
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         drv               <= '0;
         drv.path_powered  <= 1'b1;
         slow_edge_advised <= 1'b0;
      end else begin
         drv               <= drv_nxt;
         slow_edge_advised <= (out_cfg.modulation_setting < SLOW_EDGE_LIMIT)
                              && !out_cfg.slow_edge_mode; // RULE6
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_fault_hit;
      (state_r == LTXC_RUN) && fault_now;
   endsequence

   sequence s_latched;
      fault_output && fault_status && (bias_out == BIAS_ZERO);
   endsequence

   AST_FAULT_LATCH: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE21
      s_fault_hit |=> s_latched)
      else $error("fault did not zero bias and latch");

   AST_BIAS_OFF_RESET: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE12
      !bias_cfg.bias_enable |=> !bias_on && (bias_out == BIAS_ZERO))
      else $error("bias on without enable");

   AST_OPEN_LOOP: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE13
      (state_nxt == LTXC_RUN && bias_cfg.open_loop_select)
      |=> bias_out == $past(bias_cfg.bias_setting))
      else $error("open loop bias mismatch");

   AST_FAULT_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE22
      (state_r == LTXC_FAULT && enabled) |=> fault_output)
      else $error("fault released while still enabled");

   AST_CLEAR_DEASSERT: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE22
      (state_r == LTXC_FAULT && !enabled) |=> !fault_output)
      else $error("fault pin stayed during toggle");

   AST_SE_SELECT: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE2
      (out_cfg.output_mode_single_ended && out_cfg.single_ended_output_select
       && !out_cfg.transmit_path_powerdown) |=> drv.negative_out_en && !drv.positive_out_en)
      else $error("single-ended select wrong");

   AST_DIFF_DEFAULT: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE1
      (!out_cfg.output_mode_single_ended && !out_cfg.transmit_path_powerdown)
      |=> drv.positive_out_en && drv.negative_out_en)
      else $error("differential mode wrong");

   AST_POWERDOWN: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE9
      out_cfg.transmit_path_powerdown |=> !drv.path_powered && !drv.positive_out_en)
      else $error("powerdown ignored");

   AST_OFFSET: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE10
      out_cfg.offset_cancel_disable |=> !drv.offset_cancel_on)
      else $error("offset cancel not off");

   AST_MONITOR: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE17
      bias_cfg.bias_digital_monitor_select |=> digital_monitor == $past(sense.bias_current))
      else $error("bias monitor not routed");

   AST_AMP_PIN: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE7
      out_cfg.amplitude_pin_control |=> drv.amp_from_pin)
      else $error("amplitude source wrong");

endmodule

// file: ltxc_host_model.sv
// host controller model: sequences the bias enable bit and the disable pin
`timescale 1ns/100ps
module ltxc_host_model (
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       start_req,
   input  wire logic       stop_req,
   input  wire logic       recover_req,
   input  wire logic       use_pin,
   input  wire logic [7:0] hold_cyc,
   output logic            bias_enable,
   output logic            transmit_disable_pin,
   output logic            busy
);
   logic [7:0] hold_r;
   logic       pin_r;

   // enable is raised last, on request
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bias_enable          <= 1'b0;
         transmit_disable_pin <= 1'b0;
         busy                 <= 1'b0;
         hold_r               <= 8'h00;
         pin_r                <= 1'b0;
      end else if (busy) begin
         if (hold_r <= 8'h01) begin
            // short holds probe early release
            busy <= 1'b0;
            if (pin_r) begin
               transmit_disable_pin <= 1'b0;
            end else begin
               bias_enable <= 1'b1;
            end
         end else begin
            hold_r <= hold_r - 8'h01;
         end
      end else if (recover_req) begin
         busy   <= 1'b1;
         hold_r <= hold_cyc;
         pin_r  <= use_pin;
         if (use_pin) begin
            transmit_disable_pin <= 1'b1;
         end else begin
            bias_enable <= 1'b0;
         end
      end else if (start_req) begin
         bias_enable <= 1'b1;
      end else if (stop_req) begin
         bias_enable <= 1'b0;
      end
   end
endmodule

// file: ltxc_top_tb.sv
// self-checking bench for the laser transmit control and safety block
`timescale 1ns/100ps
module ltxc_top_tb;
   import ltxc_pkg::*;
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   localparam int LCYC = 4;
   logic              clk_sys;
   logic              rstn;
   ltxc_out_cfg_s     out_cfg;
   ltxc_bias_cfg_s    bcfg, bias_cfg;
   ltxc_sense_s       sense;
   logic [BIAS_W-1:0] loop_bias;
   ltxc_drv_s         drv;
   logic [BIAS_W-1:0] bias_out;
   logic              bias_sink, bias_on, photodiode_sink, closed_loop_on;
   logic [RNG_W-1:0]  photodiode_range_sel;
   logic [MON_W-1:0]  digital_monitor;
   logic              digital_monitor_valid, fault_output, fault_status, slow_edge_advised;
   logic              host_en, transmit_disable_pin, host_busy;
   logic              start_req, stop_req, recover_req, use_pin;
   logic [7:0]        hold_cyc;
   int                num_errors = 0;
   int                total_checks = 0;
   int                cycles = 0;

   ltxc_top #(.LATCH_CYC(LCYC)) u_ltxc_top (
      .clk_sys(clk_sys), .rstn(rstn), .out_cfg(out_cfg), .bias_cfg(bias_cfg),
      .sense(sense), .loop_bias(loop_bias), .transmit_disable_pin(transmit_disable_pin),
      .drv(drv), .bias_out(bias_out), .bias_sink(bias_sink), .bias_on(bias_on),
      .photodiode_sink(photodiode_sink), .photodiode_range_sel(photodiode_range_sel),
      .closed_loop_on(closed_loop_on), .digital_monitor(digital_monitor),
      .digital_monitor_valid(digital_monitor_valid), .fault_output(fault_output),
      .fault_status(fault_status), .slow_edge_advised(slow_edge_advised));

   ltxc_host_model u_ltxc_host_model (
      .clk_sys(clk_sys), .rstn(rstn), .start_req(start_req), .stop_req(stop_req),
      .recover_req(recover_req), .use_pin(use_pin), .hold_cyc(hold_cyc),
      .bias_enable(host_en), .transmit_disable_pin(transmit_disable_pin), .busy(host_busy));

   always_comb begin
      bias_cfg             = bcfg;
      bias_cfg.bias_enable = host_en;
   end

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // a hang counts as a mismatch
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic wrap_up();
      if (num_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic step(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_drv(ltxc_drv_s exp, ltxc_drv_s got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected drv: expected %h seen %h", exp, got);
      end
   endtask

   function automatic ltxc_drv_s exp_drv(ltxc_out_cfg_s c);
      ltxc_drv_s d;
      d.positive_out_en       = !c.output_mode_single_ended || !c.single_ended_output_select;
      d.negative_out_en       = !c.output_mode_single_ended || c.single_ended_output_select;
      d.deemphasis_on         = c.deemphasis_amount != 4'h0;
      d.deemphasis_level      = c.deemphasis_amount;
      d.deemphasis_wide       = c.peaking_width_select;
      d.deemphasis_delayed    = c.deemphasis_delay_mode;
      d.slow_edges            = c.slow_edge_mode;
      d.amp_from_pin          = c.amplitude_pin_control;
      d.modulation_code       = c.modulation_setting;
      d.path_powered          = !c.transmit_path_powerdown;
      d.offset_cancel_on      = !c.offset_cancel_disable;
      d.crosspoint_toward_one = c.crosspoint_sign;
      d.crosspoint_shift      = c.crosspoint_adjust;
      return d;
   endfunction

   task automatic baseline();
      @(posedge clk_sys);
      bcfg <= '{1'b0, 1'b0, 10'h155, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 8'hff, 1'b1, 8'hff};
      sense <= '{1'b0, 1'b0, 10'h010, 10'h064, 10'h064};
      loop_bias <= 10'h190;
   endtask

   // kind 0 start, 1 stop, 2 recovery toggle held for h cycles
   task automatic host_cmd(int kind, bit pin, int h);
      @(posedge clk_sys);
      start_req   <= (kind == 0);
      stop_req    <= (kind == 1);
      recover_req <= (kind == 2);
      use_pin     <= pin;
      hold_cyc    <= 8'(h);
      @(posedge clk_sys);
      start_req   <= 1'b0;
      stop_req    <= 1'b0;
      recover_req <= 1'b0;
      step(1);
   endtask

   task automatic recover(bit pin, int h);
      host_cmd(2, pin, h);
      if (h > 1) chk_val("fault_output", 1'b0, fault_output);
      for (int i = 0; i < 20 && host_busy; i++) step(1);
   endtask

   task automatic wait_on(bit on_bias, logic v);
      for (int i = 0; i < 8 && (on_bias ? bias_on : fault_output) !== v; i++) step(1);
   endtask

   // cases 0..5 latch a fault, 6..9 sit just outside one
   task automatic set_cond(int k, bit on);
      @(posedge clk_sys);
      case (k)
         0, 9: sense.bias_monitor_pin_high <= on;
         1, 6: sense.photodiode_monitor_pin_high <= on;
         2: bcfg.bias_fault_threshold <= on ? 8'h01 : 8'hff;
         3: bcfg.photodiode_fault_threshold <= on ? 8'h01 : 8'hff;
         4: sense.photodiode_current <= on ? 10'h097 : 10'h064;
         5: loop_bias <= on ? 10'h0c7 : 10'h190;
         7: sense.photodiode_current <= on ? 10'h096 : 10'h064;
         8: loop_bias <= on ? 10'h0c8 : 10'h190;
         default: ;
      endcase
      if (k == 3) bcfg.photodiode_digital_monitor_select <= on;
      if (k == 6) bcfg.analog_photodiode_fault_trigger <= !on;
      if (k == 9) bcfg.fault_detect_enable <= !on;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      ltxc_drv_s        e;
      ltxc_out_cfg_s    oc;
      logic [31:0]      r;
      logic [MON_W-1:0] m;
      logic             adv;
      rstn = 1'b0;
      out_cfg = '0;
      bcfg = '0;
      sense = '0;
      loop_bias = '0;
      {start_req, stop_req, recover_req, use_pin} = 4'h0;
      hold_cyc = 8'h00;
      void'($urandom(80818));
      baseline();
      step(8);
      e = '0;
      e.path_powered = 1'b1;
      chk_drv(e, drv);
      chk_val("bias_on", 1'b0, bias_on);
      chk_val("fault_output", 1'b0, fault_output);
      @(posedge clk_sys);
      rstn <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         r  = $urandom;
         oc = r[$bits(ltxc_out_cfg_s)-1:0];
         oc.transmit_path_powerdown = 1'b0;
         if (i < 2) begin
            oc.modulation_setting = (i == 0) ? 8'hbf : 8'hc0;
            oc.slow_edge_mode     = 1'b0;
         end
         adv = oc.modulation_setting < 8'hc0 && !oc.slow_edge_mode;
         @(posedge clk_sys);
         out_cfg <= oc;
         step(1);
         chk_drv(exp_drv(oc), drv);
         chk_val("slow_edge_advised", adv, slow_edge_advised);
      end
      for (int p = 1; p >= 0; p--) begin
         @(posedge clk_sys);
         out_cfg.transmit_path_powerdown <= p[0];
         step(1);
         chk_val("path_powered", !p[0], drv.path_powered);
      end
      for (int i = 0; i < 20; i++) begin
         r  = $urandom;
         m = r[4] ? r[16:7] : r[26:17];
         @(posedge clk_sys);
         {bcfg.open_loop_select, bcfg.photodiode_polarity, bcfg.photodiode_range} <= r[3:0];
         {bcfg.bias_sink_select, bcfg.bias_digital_monitor_select} <= r[5:4];
         bcfg.photodiode_digital_monitor_select <= r[6];
         {sense.photodiode_current, sense.bias_current} <= r[26:7];
         step(1);
         chk_val("bias_sink", r[5], bias_sink);
         chk_val("photodiode_sink", r[2], photodiode_sink);
         chk_val("photodiode_range_sel", r[1:0], photodiode_range_sel);
         chk_val("closed_loop_on", 1'b0, closed_loop_on);
         chk_val("bias_out", 10'h000, bias_out);
         chk_val("digital_monitor_valid", r[4] | r[6], digital_monitor_valid);
         if (r[4] | r[6]) chk_val("digital_monitor", m, digital_monitor);
      end
      baseline();
      @(posedge clk_sys);
      bcfg.open_loop_select <= 1'b1;
      host_cmd(0, 1'b0, 0);
      wait_on(1'b1, 1'b1);
      chk_val("bias_out", 10'h155, bias_out);
      @(posedge clk_sys);
      bcfg.open_loop_select <= 1'b0;
      step(1);
      chk_val("bias_out", 10'h190, bias_out);
      chk_val("closed_loop_on", 1'b1, closed_loop_on);
      for (int k = 0; k < 10; k++) begin
         set_cond(k, 1'b1);
         wait_on(1'b0, k < 6);
         if (k < 6) begin
            chk_val("fault_output", 1'b1, fault_output);
            chk_val("fault_status", 1'b1, fault_status);
            chk_val("bias_out", 10'h000, bias_out);
            set_cond(k, 1'b0);
            recover(k[0], LCYC);
            wait_on(1'b1, 1'b1);
            chk_val("bias_out", 10'h190, bias_out);
         end else begin
            step(3);
            chk_val("fault_output", 1'b0, fault_output);
            chk_val("bias_on", 1'b1, bias_on);
            set_cond(k, 1'b0);
         end
      end
      for (int v = 0; v < 2; v++) begin
         set_cond(0, 1'b1);
         wait_on(1'b0, 1'b1);
         if (v == 0) set_cond(0, 1'b0);
         recover(v[0], (v == 0) ? 1 : LCYC);
         wait_on(1'b0, 1'b1);
         chk_val("fault_output", 1'b1, fault_output);
         chk_val("bias_out", 10'h000, bias_out);
         set_cond(0, 1'b0);
         recover(1'b1, LCYC);
         wait_on(1'b1, 1'b1);
         chk_val("bias_on", 1'b1, bias_on);
      end
      host_cmd(1, 1'b0, 0);
      chk_val("bias_on", 1'b0, bias_on);
      wrap_up();
   end
endmodule
